// ### hw/swid_pkg.sv
// Package for the single-wire identity link slave: timing, layout, states
package swid_pkg;
   // Clock rate and timing figures, given in ns
   localparam int CLK_PERIOD_NS   = 40;
   localparam int RESET_MIN_NS    = 480000;
   localparam int PRES_WAIT_NS    = 30000;
   localparam int PRES_LEN_NS     = 120000;
   localparam int SAMPLE_NS       = 30000;
   localparam int ZERO_HOLD_NS    = 45000;
   // Least times round up, lengths and holds round down
   localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int PRES_WAIT_CYC = (PRES_WAIT_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int PRES_LEN_CYC  = PRES_LEN_NS / CLK_PERIOD_NS;
   localparam int SAMPLE_CYC    = (SAMPLE_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int ZERO_HOLD_CYC = ZERO_HOLD_NS / CLK_PERIOD_NS;
   localparam int CNT_W         = 16;

   // Identity layout, 64 bits
   localparam int ID_W          = 64;
   localparam int BYTE_W        = 8;
   localparam int SER_W         = 48;
   localparam int TYPE_W        = 7;
   localparam int CUST_CODE_W   = 12;
   localparam int CUST_REST_W   = 36;
   localparam int OPT_A_W       = 8;
   localparam int OPT_B_W       = 12;
   localparam int OPT_C_W       = 16;
   localparam int OPT_D_W       = 20;
   localparam int CUST_FLAG_BIT = 7;
   localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
   localparam logic [7:0] CRC_INIT      = 8'h00;
   localparam logic [7:0] ROM_READ_CMD  = 8'h33;

   localparam int FIFO_DEPTH    = 32;
   localparam int BIT_CNT_W     = 6;
   localparam logic [5:0] BIT_LAST = 6'h3F;
   localparam logic [2:0] BYTE_LAST = 3'h7;

   typedef enum logic [1:0] {
      SWID_OPT_A,
      SWID_OPT_B,
      SWID_OPT_C,
      SWID_OPT_D
   } swid_opt_t;

   typedef enum {
      SWID_WAIT_HIGH,
      SWID_PRES_GAP,
      SWID_PRES_PULSE,
      SWID_CMD,
      SWID_SEND,
      SWID_DATA,
      SWID_IDLE
   } swid_state_t;
endpackage

// ### hw/swid_fifo.sv
// Small valid/ready FIFO with parameter width and depth
`timescale 1ns/100ps
module swid_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign push      = ce && in_valid && in_ready;
   assign pop       = ce && out_valid && out_ready;
   assign out_data  = mem_r[rp_r];

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule

// ### hw/swid_slave.sv
// Single-wire identity link slave: presence, slots, identity readout
`timescale 1ns/100ps
module swid_slave
   import swid_pkg::*;
#(
   parameter logic [6:0]  DEV_TYPE   = 7'h01, // Arbitrary value
   parameter logic        CUST_FLAG  = 1'b0,
   parameter logic [11:0] CUST_CODE  = 12'h000, // Arbitrary value
   parameter swid_opt_t   CUST_OPT   = SWID_OPT_A,
   parameter logic [19:0] CUST_DATA  = 20'h00000, // Arbitrary value
   parameter logic [47:0] SERIAL     = 48'h000000000001, // Arbitrary
   parameter int          RESET_MIN  = RESET_MIN_CYC,
   parameter int          PRES_WAIT  = PRES_WAIT_CYC,
   parameter int          PRES_LEN   = PRES_LEN_CYC,
   parameter int          SAMPLE_DLY = SAMPLE_CYC,
   parameter int          ZERO_HOLD  = ZERO_HOLD_CYC
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       dq_in,
   output logic            dq_out,
   output logic            dq_oe,
   output logic [7:0]      cmd_data,
   output logic            cmd_valid,
   input  wire logic       cmd_ready,
   output logic            presence_busy
);
   import swid_pkg::*;

   function automatic logic [7:0] crc_step(input logic [7:0] crc,
                                            input logic       b);
      logic fb;
      fb = crc[0] ^ b;
      crc_step = (crc >> 1) ^ (fb ? CRC_POLY_REFL : 8'h00);
   endfunction

   function automatic logic [7:0] crc_bytes(input logic [55:0] d);
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = 0; i < ID_W - BYTE_W; i++) begin
         c = crc_step(c, d[i]);
      end
      crc_bytes = c;
   endfunction

   // Last cycle of an n-cycle phase; n of zero ends at once
   function automatic logic cnt_done(input logic [CNT_W-1:0] c,
                                     input int               n);
      cnt_done = (int'(c) + 1 >= n);
   endfunction

   // Customer field split; serial bits under the field keep SERIAL
   function automatic logic [47:0] build_serial();
      logic [47:0] s;
      int          w;
      s = SERIAL;
      w = (CUST_OPT == SWID_OPT_A) ? OPT_A_W :
          (CUST_OPT == SWID_OPT_B) ? OPT_B_W :
          (CUST_OPT == SWID_OPT_C) ? OPT_C_W : OPT_D_W;
      if (CUST_FLAG) begin
         s[SER_W-1 -: CUST_CODE_W] = CUST_CODE;
         for (int i = 0; i < OPT_D_W; i++) begin
            if (i >= OPT_D_W - w) begin
               s[CUST_REST_W - OPT_D_W + i] = CUST_DATA[i];
            end
         end
      end
      build_serial = s;
   endfunction

   localparam logic [7:0]  TYPE_BYTE = {CUST_FLAG, DEV_TYPE};
   localparam logic [47:0] SER_FULL  = build_serial();
   localparam logic [55:0] ID_LOW    = {SER_FULL, TYPE_BYTE};
   // Type byte in bits 7:0 goes first, serial low byte next
   localparam logic [63:0] ID_WORD   = {crc_bytes(ID_LOW), ID_LOW};

   swid_state_t          state_r;
   logic                 line_d_r;
   logic [CNT_W-1:0]     low_cnt_r;
   logic [CNT_W-1:0]     t_r;
   logic                 slot_act_r;
   logic                 hold_r;
   logic [BIT_CNT_W-1:0] bit_r;
   logic [7:0]           shreg_r;
   logic                 fifo_in_valid;
   logic                 fifo_in_ready;
   logic                 fall;
   logic                 reset_seen;
   logic                 sample;
   logic [CNT_W-1:0]     pres_cnt_r;
   logic                 rd_act_r;
   logic                 rd_end;
   logic                 gap_done;
   logic                 pulse_done;
   logic                 slot_arm;

   assign fall       = line_d_r && !dq_in;
   assign reset_seen = (low_cnt_r >= CNT_W'(RESET_MIN));
   assign sample     = slot_act_r && (t_r == CNT_W'(SAMPLE_DLY));
   assign dq_out     = 1'b0;
   assign presence_busy = (state_r == SWID_PRES_PULSE);
   assign gap_done   = cnt_done(pres_cnt_r, PRES_WAIT);
   assign pulse_done = cnt_done(pres_cnt_r, PRES_LEN);
   // Our own presence low must not look like a master slot
   assign slot_arm   = (state_r == SWID_CMD) || (state_r == SWID_DATA);
   assign rd_end     = rd_act_r && slot_act_r
                       && (t_r == CNT_W'(SAMPLE_DLY + ZERO_HOLD));

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         line_d_r  <= 1'b1;
         low_cnt_r <= '0;
      end else if (ce) begin
         line_d_r <= dq_in;
         if (dq_in) begin
            low_cnt_r <= '0;
         end else if (!reset_seen) begin
            low_cnt_r <= low_cnt_r + 1'b1;
         end
      end
   end

   // Slot timer restarts on every falling edge in CMD or DATA, so gaps do not matter
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         t_r        <= '0;
         slot_act_r <= 1'b0;
      end else if (ce) begin
         if (fall && slot_arm) begin
            t_r        <= '0;
            slot_act_r <= 1'b1;
         end else if (slot_act_r) begin
            t_r <= t_r + 1'b1;
            if (t_r >= CNT_W'(SAMPLE_DLY + ZERO_HOLD)) begin
               slot_act_r <= 1'b0;
            end
         end
      end
   end

   // Gap and pulse timer; the slot timer is left to master slots
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pres_cnt_r <= '0;
      end else if (ce) begin
         if (state_r == SWID_PRES_GAP && dq_in && !gap_done) begin
            pres_cnt_r <= pres_cnt_r + 1'b1;
         end else if (state_r == SWID_PRES_PULSE && !pulse_done) begin
            pres_cnt_r <= pres_cnt_r + 1'b1;
         end else begin
            pres_cnt_r <= '0;
         end
      end
   end

   // Start in WAIT_HIGH so first contact yields a presence pulse
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r <= SWID_WAIT_HIGH;
      end else if (ce) begin
         if (reset_seen && state_r != SWID_WAIT_HIGH) begin
            state_r <= SWID_WAIT_HIGH;
         end else begin
            unique case (state_r)
               SWID_WAIT_HIGH: begin
                  if (dq_in) begin
                     state_r <= SWID_PRES_GAP;
                  end
               end
               SWID_PRES_GAP: begin
                  if (!dq_in) begin
                     state_r <= SWID_WAIT_HIGH;
                  end else if (gap_done) begin
                     state_r <= SWID_PRES_PULSE;
                  end
               end
               SWID_PRES_PULSE: begin
                  if (pulse_done) begin
                     state_r <= SWID_CMD;
                  end
               end
               SWID_CMD: begin
                  if (sample && bit_r[2:0] == BYTE_LAST) begin
                     state_r <= SWID_SEND;
                  end
               end
               SWID_SEND: begin
                  // A full queue stalls here; the byte waits, not lost
                  if (fifo_in_ready) begin
                     state_r <= (shreg_r == ROM_READ_CMD) ? SWID_DATA
                                                          : SWID_IDLE;
                  end
               end
               SWID_DATA: begin
                  if (rd_end && bit_r == BIT_LAST) begin
                     state_r <= SWID_IDLE;
                  end
               end
               SWID_IDLE: begin
                  state_r <= SWID_IDLE;
               end
            endcase
         end
      end
   end

   // Bit counter: command bits in CMD, identity bits in DATA
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bit_r <= '0;
      end else if (ce) begin
         if (state_r == SWID_CMD) begin
            if (sample) begin
               bit_r <= (bit_r[2:0] == BYTE_LAST) ? '0 : bit_r + 1'b1;
            end
         end else if (state_r == SWID_DATA) begin
            if (rd_end) begin
               bit_r <= bit_r + 1'b1;
            end
         end else begin
            bit_r <= '0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         shreg_r <= '0;
      end else if (ce) begin
         if (state_r == SWID_CMD && sample) begin
            shreg_r <= {dq_in, shreg_r[7:1]};
         end
      end
   end

   // Read slot tracker: a slot must outlast SAMPLE_DLY+ZERO_HOLD,
   // otherwise the bit index does not advance
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hold_r   <= 1'b0;
         rd_act_r <= 1'b0;
      end else if (ce) begin
         if (reset_seen || state_r != SWID_DATA) begin
            hold_r   <= 1'b0;
            rd_act_r <= 1'b0;
         end else if (fall) begin
            hold_r   <= !ID_WORD[bit_r];
            rd_act_r <= 1'b1;
         end else if (rd_end) begin
            hold_r   <= 1'b0;
            rd_act_r <= 1'b0;
         end
      end
   end

   assign fifo_in_valid = (state_r == SWID_SEND);
   // Only ever a pull-down: presence pulse or a stretched zero
   assign dq_oe = hold_r || (state_r == SWID_PRES_PULSE);

   swid_fifo #(
      .WIDTH (BYTE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst       (rst),
      .ce        (ce),
      .in_data   (shreg_r),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .out_data  (cmd_data),
      .out_valid (cmd_valid),
      .out_ready (cmd_ready)
   );

   chk_zero_hold: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == SWID_DATA && fall && !ID_WORD[bit_r] && ce)
      |=> dq_oe) else $error("zero bit not held low");
   chk_one_free: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == SWID_DATA && fall && ID_WORD[bit_r] && ce)
      |=> !hold_r) else $error("one bit drove the line");
   chk_reset_pres: assert property (@(posedge core_clk) disable iff (rst)
      (reset_seen && ce && state_r == SWID_DATA)
      |=> state_r == SWID_WAIT_HIGH) else $error("reset missed");
   chk_pres_only: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == SWID_CMD) |-> !dq_oe)
      else $error("drove line in command");
   chk_drive_low: assert property (@(posedge core_clk) disable iff (rst)
      dq_out == 1'b0) else $error("line driven high");
   chk_wait_high: assert property (@(posedge core_clk) disable iff (rst)
      (ce && state_r == SWID_WAIT_HIGH && dq_in)
      |=> state_r == SWID_PRES_GAP) else $error("no gap after high");
   chk_pulse_len: assert property (@(posedge core_clk) disable iff (rst)
      (ce && state_r == SWID_PRES_PULSE && !reset_seen
       && pres_cnt_r == CNT_W'(PRES_LEN - 1))
      |=> state_r == SWID_CMD) else $error("pulse length wrong");
   chk_cmd_push: assert property (@(posedge core_clk) disable iff (rst)
      (ce && state_r == SWID_SEND && fifo_in_ready)
      |=> cmd_valid) else $error("command byte not queued");
   chk_hold_end: assert property (@(posedge core_clk) disable iff (rst)
      (ce && rd_end && !fall && !reset_seen)
      |=> !hold_r) else $error("zero hold not released");
   cov_presence: cover property (@(posedge core_clk)
      state_r == SWID_PRES_PULSE);
   cov_cmd_byte: cover property (@(posedge core_clk) cmd_valid);
   cov_readout: cover property (@(posedge core_clk)
      state_r == SWID_DATA ##1 state_r == SWID_IDLE);
   cov_zero_bit: cover property (@(posedge core_clk) hold_r);
   cov_abort: cover property (@(posedge core_clk)
      state_r == SWID_DATA ##1 state_r == SWID_WAIT_HIGH);
endmodule

// ### sim/swid_master.sv
// Bus master model for the single data line
`timescale 1ns/100ps
module swid_master #(
   parameter int SMP = 8,
   parameter int ZH  = 10
) (
   input  wire logic core_clk,
   input  wire logic dq,
   output logic      drive_low
);
   initial drive_low = 1'b0;

   // Long low forces the device to announce itself again
   task automatic reset_pulse(input int n);
      @(negedge core_clk) drive_low = 1'b1;
      repeat (n) @(negedge core_clk);
      drive_low = 1'b0;
   endtask

   // Slot timed from our own falling edge; a read is a write-one slot
   task automatic slot(input logic b, output logic rd, output logic held,
                       output logic rel);
      @(negedge core_clk) drive_low = 1'b1;
      for (int k = 1; k <= SMP + ZH + 4; k++) begin
         @(negedge core_clk);
         if (k == 2 && b)
            drive_low = 1'b0;
         if (k == SMP + 2)
            rd = dq;
         if (k == SMP + 3)
            drive_low = 1'b0;
         if (k == SMP + ZH - 2)
            held = dq;
      end
      // Late look: a zero must be released by now
      rel = dq;
   endtask
endmodule

// ### sim/tb_single_wire_slave_id_link.sv
// Testbench for the single-wire identity link slave
`timescale 1ns/100ps
module tb_single_wire_slave_id_link;
   import swid_pkg::*;
   localparam int          RMIN = 50;
   localparam int          PLEN = 20;
   localparam int          SMP  = 8;
   localparam int          ZH   = 10;
   localparam logic [6:0]  TYP  = 7'h2A;
   localparam logic [11:0] CC   = 12'h5B3;
   localparam logic [19:0] CD   = 20'hA50A5;
   localparam logic [47:0] SER  = 48'h123456789ABC;
   logic       core_clk  = 1'b0;
   logic       rst       = 1'b1;
   logic       ce        = 1'b1;
   logic       cmd_ready = 1'b0;
   logic       dq;
   logic       dq_out;
   logic       dq_oe;
   logic       cmd_valid;
   logic       presence_busy;
   logic       m_low;
   logic [7:0] cmd_data;
   int         err_total = 0;
   int         checked   = 0;

   always #20 core_clk = ~core_clk;
   // Pull-up resistor: line low whenever either side pulls
   assign dq = ~(m_low | dq_oe);

   swid_slave #(.DEV_TYPE(TYP), .CUST_FLAG(1'b1), .CUST_CODE(CC),
      .CUST_OPT(SWID_OPT_A), .CUST_DATA(CD), .SERIAL(SER),
      .RESET_MIN(RMIN), .PRES_WAIT(10), .PRES_LEN(PLEN),
      .SAMPLE_DLY(SMP), .ZERO_HOLD(ZH)) DUT (
      .core_clk(core_clk), .rst(rst), .ce(ce), .dq_in(dq),
      .dq_out(dq_out), .dq_oe(dq_oe), .cmd_data(cmd_data),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .presence_busy(presence_busy));

   swid_master #(.SMP(SMP), .ZH(ZH)) m (
      .core_clk(core_clk), .dq(dq), .drive_low(m_low));

   task automatic conclude;
      $display("mismatches %0d, checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic chk1(input logic s, input logic e);
      chk({63'h0, s}, {63'h0, e});
   endtask

   function automatic logic [7:0] crc8(input logic [55:0] d);
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = 0; i < 56; i++)
         c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
      return c;
   endfunction

   task automatic presence;
      int t;
      int w;
      t = 0;
      w = 0;
      while (dq_oe !== 1'b1 && t < 2000) begin
         @(negedge core_clk);
         t++;
      end
      chk1(dq_oe, 1'b1);
      chk1(presence_busy, 1'b1);
      chk1(dq_out, 1'b0);
      while (dq_oe === 1'b1 && w < 1000) begin
         @(negedge core_clk);
         w++;
      end
      chk1(w >= PLEN - 1 && w <= PLEN + 2, 1'b1);
      repeat (4) @(negedge core_clk);
   endtask

   // Gaps grow from bit to bit to prove slots need no fixed pace
   task automatic send(input logic [7:0] v);
      logic a;
      logic h;
      logic l;
      for (int i = 0; i < 8; i++) begin
         m.slot(v[i], a, h, l);
         repeat (1 + 3 * i) @(negedge core_clk);
      end
   endtask

   task automatic pop(input logic [7:0] e);
      chk1(cmd_valid, 1'b1);
      chk({56'h0, cmd_data}, {56'h0, e});
      cmd_ready = 1'b1;
      @(negedge core_clk);
      cmd_ready = 1'b0;
      @(negedge core_clk);
   endtask

   task automatic open_cmd(input logic [7:0] v);
      m.reset_pulse(RMIN + 10);
      presence();
      send(v);
   endtask

   task automatic id_read;
      logic [63:0] r;
      logic [63:0] e;
      logic        h;
      logic        l;
      e[7:0] = {1'b1, TYP};
      e[55:8] = {CC, CD[19:12], SER[27:0]};
      e[63:56] = crc8(e[55:0]);
      open_cmd(ROM_READ_CMD);
      pop(ROM_READ_CMD);
      for (int i = 0; i < 64; i++) begin
         m.slot(1'b1, r[i], h, l);
         chk1(h, r[i]);
         chk1(l, 1'b1);
         repeat (2) @(negedge core_clk);
      end
      chk(r, e);
   endtask

   // Reset pulse cuts a readout short, then a foreign command idles it
   task automatic abort_idle;
      logic a;
      logic h;
      logic l;
      open_cmd(ROM_READ_CMD);
      pop(ROM_READ_CMD);
      repeat (5) m.slot(1'b1, a, h, l);
      fork
         m.reset_pulse(RMIN + 10);
         begin
            repeat (RMIN + 5) @(negedge core_clk);
            chk1(dq_oe, 1'b0);
         end
      join
      presence();
      send(8'hC4);
      pop(8'hC4);
      repeat (8) begin
         m.slot(1'b1, a, h, l);
         chk1(a, 1'b1);
      end
   endtask

   // Thirty-three bytes into thirty-two places: the last waits for room
   task automatic fill_drain;
      for (int i = 0; i < 33; i++)
         open_cmd(8'h40 + i[7:0]);
      for (int i = 0; i < 33; i++)
         pop(8'h40 + i[7:0]);
      chk1(cmd_valid, 1'b0);
   endtask

   initial begin
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      presence();
      id_read();
      abort_idle();
      fill_drain();
      conclude();
   end

   initial begin
      repeat (60000) @(posedge core_clk);
      err_total++;
      conclude();
   end
endmodule
